// ==== logic/mbhp_map.vh ====
// Constants for the muxed bus host port
`ifndef MBHP_MAP_VH
`define MBHP_MAP_VH

// ----------------------------------------
// Power-up hold-off
// ----------------------------------------
`define MBHP_CLK_HZ        50000000
`define MBHP_HOLDOFF_MS    200
`define MBHP_HOLDOFF_CYC   (`MBHP_CLK_HZ / 1000 * `MBHP_HOLDOFF_MS)
`define MBHP_HOLD_W        24

// ----------------------------------------
// Bus widths and reset values
// ----------------------------------------
`define MBHP_DW            8
`define MBHP_BYTE_ZERO     8'h00
`define MBHP_BYTE_ONES     8'hff

`endif

// ==== logic/mbhp_sync.v ====
// Two-stage synchroniser with a registered copy for edge detection
`timescale 1ns/100ps
module mbhp_sync #(
    parameter W = 1,
    parameter [W-1:0] INIT = {W{1'b0}}
)(
    input  wire         i_mclk,
    input  wire         i_rstn,
    input  wire [W-1:0] i_async,
    output reg  [W-1:0] o_sync,
    output reg  [W-1:0] o_prev
);
    reg [W-1:0] meta;

    // First stage is read only by the second
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            meta   <= INIT;
            o_sync <= INIT;
            o_prev <= INIT;
        end
        else
        begin
            meta   <= i_async;
            o_sync <= meta;
            o_prev <= o_sync;
        end
    end
endmodule // mbhp_sync

// ==== logic/mbhp_port.v ====
// Muxed address/data host port of the clock/calendar device
//
// Behaviour
// - Selector high picks strobe-with-direction; low or open picks separate strobes.
// - Address on the muxed bus is captured when the address strobe falls.
// - Every address strobe rise discards the held address, chip select or not.
// - Write data taken on data strobe fall, or on write strobe rise.
// - Read data driven in the late cycle phase per bus style.
// - Read ends and bus floats on data strobe fall, or read strobe rise.
// - Deselected cycles still capture address but perform no access.
// - Below the power-fail threshold chip select is forced inactive.
// - Direction high during data strobe reads; low during data strobe writes.
// - In separate-strobe style the read/write line is an active-low write strobe.
// - No access while the reset input is low.
// - A power-up timer holds off access for up to 200 ms.
`timescale 1ns/100ps
`include "mbhp_map.vh"
module mbhp_port #(
    parameter DW         = `MBHP_DW,
    parameter HOLD_W     = `MBHP_HOLD_W,
    parameter HOLDOFF_CY = `MBHP_HOLDOFF_CYC
)(
    input  wire          i_mclk,
    input  wire          i_rstn,
    input  wire          i_bus_style_select,
    input  wire          i_address_latch_strobe,
    input  wire          i_chip_select_n,
    input  wire          i_data_or_read_strobe,
    input  wire          i_read_write,
    input  wire          i_power_fail,
    input  wire [DW-1:0] i_muxed_addr_data_bus,
    output reg  [DW-1:0] o_muxed_addr_data_bus,
    output reg           o_muxed_addr_data_oe,
    input  wire [DW-1:0] i_rd_data,
    output reg  [DW-1:0] o_addr,
    output reg           o_addr_valid,
    output reg           o_wr_stb,
    output reg  [DW-1:0] o_wr_data,
    output reg           o_rd_stb,
    output reg           o_ready
);
    // ----------------------------------------
    // Synchronisers
    // ----------------------------------------
    // Strobe sync costs two cycles of latency; address is sampled in the cycle the
    // strobe edge is seen and write data a cycle before, relying on host hold time.
    wire [3:0] s_now;
    wire [3:0] s_old;
    mbhp_sync #(.W(4), .INIT(4'hc)) u_sync (
        .i_mclk  (i_mclk),
        .i_rstn  (i_rstn),
        .i_async ({i_chip_select_n, i_read_write,
                   i_data_or_read_strobe, i_address_latch_strobe}),
        .o_sync  (s_now),
        .o_prev  (s_old)
    );
    wire as_now = s_now[0];
    wire ds_now = s_now[1];
    wire rw_now = s_now[2];
    wire cs_n   = s_now[3];
    wire as_rise = as_now & ~s_old[0];
    wire as_fall = ~as_now & s_old[0];
    wire ds_rise = ds_now & ~s_old[1];
    wire ds_fall = ~ds_now & s_old[1];
    wire rw_rise = rw_now & ~s_old[2];

    reg [DW-1:0] bus_q;
    reg          style;
    reg          style_taken;
    reg [HOLD_W-1:0] hold_cnt;

    // ----------------------------------------
    // Strap capture and power-up hold-off
    // ----------------------------------------
    // Strap sampled once after reset release, never under async reset
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            style       <= 1'b0;
            style_taken <= 1'b0;
            hold_cnt    <= {HOLD_W{1'b0}};
            o_ready     <= 1'b0;
            bus_q       <= `MBHP_BYTE_ZERO;
        end
        else
        begin
            bus_q <= i_muxed_addr_data_bus;
            if (!style_taken)
            begin
                style       <= i_bus_style_select;
                style_taken <= 1'b1;
            end
            if (hold_cnt != HOLDOFF_CY[HOLD_W-1:0])
                hold_cnt <= hold_cnt + 1'b1;
            o_ready <= (hold_cnt == HOLDOFF_CY[HOLD_W-1:0]) & style_taken;
        end
    end

    // Chip select gated by power-fail, reset and hold-off
    wire sel = ~cs_n & ~i_power_fail & o_ready;

    // ----------------------------------------
    // Access decode per bus style
    // ----------------------------------------
    reg wr_evt;
    reg rd_phase;
    reg rd_start;
    always @*
    begin
        if (style)
        begin
            wr_evt   = ds_fall & ~rw_now;
            rd_phase = ds_now & rw_now;
            rd_start = ds_rise & rw_now;
        end
        else
        begin
            wr_evt   = rw_rise & ds_now;
            rd_phase = ~ds_now & rw_now;
            rd_start = ~ds_now & s_old[1] & rw_now;
        end
    end

    // ----------------------------------------
    // Address, write and read handling
    // ----------------------------------------
    always @(posedge i_mclk or negedge i_rstn)
    begin
        if (!i_rstn)
        begin
            o_addr                <= `MBHP_BYTE_ZERO;
            o_addr_valid          <= 1'b0;
            o_wr_stb              <= 1'b0;
            o_wr_data             <= `MBHP_BYTE_ZERO;
            o_rd_stb              <= 1'b0;
            o_muxed_addr_data_bus <= `MBHP_BYTE_ZERO;
            o_muxed_addr_data_oe  <= 1'b0;
        end
        else
        begin
            o_wr_stb <= 1'b0;
            o_rd_stb <= 1'b0;
            if (as_rise)
                o_addr_valid <= 1'b0;
            else if (as_fall)
            begin
                o_addr       <= i_muxed_addr_data_bus;
                o_addr_valid <= 1'b1;
            end
            // Address is consumed by one access; a deselected write also uses it up, a deselected read does not
            if (wr_evt && o_addr_valid && !as_now)
            begin
                o_addr_valid <= 1'b0;
                if (sel)
                begin
                    o_wr_stb  <= 1'b1;
                    o_wr_data <= bus_q;
                end
            end
            if (rd_start && o_addr_valid && sel)
                o_rd_stb <= 1'b1;
            // Drive only while selected and in read phase
            if (rd_phase && sel && o_addr_valid && !as_now)
            begin
                o_muxed_addr_data_oe  <= 1'b1;
                o_muxed_addr_data_bus <= i_rd_data;
            end
            else
            begin
                o_muxed_addr_data_oe  <= 1'b0;
                o_muxed_addr_data_bus <= `MBHP_BYTE_ZERO;
            end
            if (o_muxed_addr_data_oe && !rd_phase)
                o_addr_valid <= 1'b0;
        end
    end
endmodule // mbhp_port

// ==== tb/mbhp_port_sva.sv ====
// Checker of the muxed bus host port
`timescale 1ns/100ps
module mbhp_chk (
    input wire logic       i_mclk,
    input wire logic       i_rstn,
    input wire logic       i_bus_style_select,
    input wire logic       i_address_latch_strobe,
    input wire logic       i_chip_select_n,
    input wire logic       i_data_or_read_strobe,
    input wire logic       i_power_fail,
    input wire logic [7:0] i_muxed_addr_data_bus,
    input wire logic [7:0] i_rd_data,
    input wire logic [7:0] o_muxed_addr_data_bus,
    input wire logic       o_muxed_addr_data_oe,
    input wire logic [7:0] o_addr,
    input wire logic       o_addr_valid,
    input wire logic       o_wr_stb,
    input wire logic       o_rd_stb,
    input wire logic       o_ready
);
    default clocking @(posedge i_mclk); endclocking
    default disable iff (!i_rstn);
    sequence as_fall;
        $fell(i_address_latch_strobe);
    endsequence
    sequence rd_end;
        i_bus_style_select ? $fell(i_data_or_read_strobe) : $rose(i_data_or_read_strobe);
    endsequence
    addr_take_a: assert property (as_fall |-> ##4 o_addr_valid &&
        o_addr == $past(i_muxed_addr_data_bus, 4)) else $error("address not captured");
    addr_drop_a: assert property ($rose(i_address_latch_strobe) |-> ##[1:5] !o_addr_valid)
        else $error("address kept");
    wr_pulse_a: assert property (o_wr_stb |=> !o_wr_stb) else $error("long write");
    rd_pulse_a: assert property (o_rd_stb |=> !o_rd_stb) else $error("long read");
    acc_gate_a: assert property (o_wr_stb || o_rd_stb |-> $past(o_addr_valid) && o_ready)
        else $error("access without address");
    cs_off_a: assert property (i_chip_select_n [*6] |-> !o_wr_stb && !o_rd_stb)
        else $error("deselected access");
    pf_off_a: assert property (i_power_fail [*2] |-> !o_wr_stb && !o_rd_stb)
        else $error("access in power fail");
    float_a: assert property (!o_muxed_addr_data_oe |-> o_muxed_addr_data_bus == 8'h00)
        else $error("bus not idle");
    rd_data_a: assert property (o_muxed_addr_data_oe |->
        o_muxed_addr_data_bus == $past(i_rd_data)) else $error("bad read data");
    rd_end_a: assert property (rd_end |-> ##[1:5] !o_muxed_addr_data_oe)
        else $error("read not ended");
endmodule // mbhp_chk
bind mbhp_port mbhp_chk u_chk (.*);

// ==== tb/mbhp_host.sv ====
// Host processor model driving the muxed bus
`timescale 1ns/100ps
module mbhp_host (
    input wire logic       i_mclk,
    input wire logic       i_sel,
    input wire logic [7:0] i_dq,
    output logic           o_as = 1'b0,
    output logic           o_cs_n = 1'b1,
    output logic           o_ds = 1'b0,
    output logic           o_rw = 1'b1,
    output logic [7:0]     o_bus = 8'h00
);
    logic [7:0] got;
    task cyc(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            @(negedge i_mclk);
            o_bus = a;
            o_as = 1'b1;
            o_cs_n = c;
            repeat (4) @(negedge i_mclk);
            o_as = 1'b0;
            repeat (5) @(negedge i_mclk);
            o_bus = w ? d : ~a; // Released bus shows the inverse, not stale data
            o_rw = !w;
            o_ds = i_sel | w;
            repeat (6) @(negedge i_mclk);
            got = i_dq;
            o_ds = !i_sel;
            o_rw = i_sel ? o_rw : 1'b1;
            repeat (5) @(negedge i_mclk);
            o_rw = 1'b1;
            o_bus = ~o_bus;
            o_cs_n = 1'b1;
        end
    endtask
endmodule // mbhp_host

// ==== tb/muxed_bus_host_port_bench.sv ====
// Self-checking bench of the muxed bus host port
`timescale 1ns/100ps
module muxed_bus_host_port_bench;
    logic        clk = 1'b0, rstn = 1'b0, sel = 1'b1, pf = 1'b0;
    logic [7:0]  rdd = 8'h00, dq, bus, adr, wd;
    logic        as, csn, ds, rw, oe, ws, rs, rdy, av;
    logic [16:0] q[$];
    logic [16:0] n;
    int          miscompares = 0, checked = 0;
    always #10 clk = ~clk;
    mbhp_host host (.i_mclk(clk), .i_sel(sel), .i_dq(dq), .o_as(as), .o_cs_n(csn),
        .o_ds(ds), .o_rw(rw), .o_bus(bus));
    mbhp_port #(.HOLDOFF_CY(16)) dut (.i_mclk(clk), .i_rstn(rstn), .i_bus_style_select(sel),
        .i_address_latch_strobe(as), .i_chip_select_n(csn), .i_data_or_read_strobe(ds),
        .i_read_write(rw), .i_power_fail(pf), .i_muxed_addr_data_bus(bus),
        .o_muxed_addr_data_bus(dq), .o_muxed_addr_data_oe(oe), .i_rd_data(rdd), .o_addr(adr),
        .o_addr_valid(av), .o_wr_stb(ws), .o_wr_data(wd), .o_rd_stb(rs), .o_ready(rdy));
    task chk(input string s, input logic [16:0] e, input logic [16:0] g);
        begin
            checked++;
            if (g !== e)
            begin
                miscompares++;
                $display("wrong value %s exp %h got %h", s, e, g);
            end
        end
    endtask
    task end_of_test;
        begin
            if (miscompares == 0 && checked > 0)
                $display("Simulation passed");
            else
                $display("Simulation failed");
            $finish;
        end
    endtask
    task start(input logic s);
        begin
            rstn = 1'b0;
            sel = s;
            host.o_ds = !s;
            repeat (2) @(negedge clk);
            rstn = 1'b1;
            repeat (10) @(negedge clk);
            chk("early ready", 17'h0, {16'h0, rdy});
            repeat (20) if (rdy !== 1'b1) @(negedge clk);
            chk("ready", 17'h1, {16'h0, rdy});
        end
    endtask
    task acc(input logic c, input logic w, input logic [7:0] a, input logic [7:0] d);
        begin
            rdd = d;
            if (!c && !pf)
                q.push_back({w, a, d});
            host.cyc(c, w, a, d);
            if (!w && !c && !pf)
                chk("read data", {9'h0, d}, {9'h0, host.got});
            if (!c && !pf)
                chk("addr used", 17'h0, {16'h0, av});
        end
    endtask
    // Outputs settle after the rising edge; look at them mid-cycle
    always @(negedge clk)
        if (ws === 1'b1 || rs === 1'b1)
        begin
            n = q.pop_front();
            chk("access", n, {ws, adr, ws ? wd : rdd});
        end
    initial
    begin
        void'($urandom(43440));
        for (int m = 1; m >= 0; m--)
        begin
            start(m[0]);
            acc(1'b0, 1'b1, 8'h00, 8'hff);
            acc(1'b0, 1'b0, 8'hff, 8'h00);
            repeat (12)
            begin
                pf = ($urandom % 5) == 0;
                acc(($urandom % 4) == 0, 1'($urandom), 8'($urandom), 8'($urandom));
            end
            pf = 1'b0;
        end
        chk("pending", 17'h0, 17'(q.size()));
        end_of_test;
    end
    // Covers both styles with margin for the hold-off waits
    initial
    begin
        #100000;
        miscompares++;
        end_of_test;
    end
endmodule // muxed_bus_host_port_bench
